// ===== hdl/bcl_pkg.sv
// package: constants, types and register map of the commutation logic
package bcl_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned OSC_HZ = 25000;
  localparam logic [15:0] PERIOD_RST = 16'(CLK_HZ / OSC_HZ);
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0fa0;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] PERIOD_OFS = 8'h00;
  localparam logic [7:0] LEVEL_OFS = 8'h04;
  localparam logic [7:0] CONFIG_OFS = 8'h08;
  localparam logic [7:0] DELAY_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  localparam int CFG_LATCH_MODE = 0;
  localparam int CFG_LATCH_CLR = 1;
  localparam int EV_INVALID = 0;
  localparam int EV_TRIP = 1;
  localparam int EV_LATCH = 2;
  localparam int EV_SUPPLY = 3;
  localparam int NEV = 4;
  localparam logic [2:0] STEP_BAD = 3'h7;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic run_en;
    logic brake;
    logic sel60;
    logic fwd;
    logic uvlo;
    logic tsd;
    logic cur_trip;
    logic [2:0] hall;
  } bcl_ctl_s;

  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } bcl_drv_s;

  typedef enum logic [1:0] {
    BCL_IDLE = 2'b01,
    BCL_ACK = 2'b10
  } bcl_bus_e;

endpackage : bcl_pkg

// ===== hdl/bcl_core.sv
// module: six-step commutation, pwm, protection and register slave
//
// Added by the designer: register access over Avalon-MM and the register offsets.
module bcl_core (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // motor pins
  input bcl_pkg::bcl_ctl_s ctl,
  output bcl_pkg::bcl_drv_s drv,
  output logic fault_out,
  output logic fault_oe_n,
  // interrupt
  output logic irq
);
  import bcl_pkg::*;

  typedef struct packed {
    bcl_bus_e bus;
    logic [31:0] rdata;
    logic [15:0] ramp;
    logic [15:0] period;
    logic [15:0] level;
    logic [15:0] delay;
    logic [15:0] dly_cnt;
    logic latch_mode;
    logic latched;
    logic cl_cyc;
    bcl_drv_s drv;
    logic fault;
    logic [NEV-1:0] ev_prev;
    logic [NEV-1:0] irq_st;
    logic [NEV-1:0] irq_mask;
  } bcl_state_s;

  bcl_state_s s_reg, s_next;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // sensor code {a,b,c} to step 0..5, STEP_BAD for the two invalid codes
  function automatic logic [2:0] hall_step(input logic [2:0] h,
                                           input logic sel60);
    logic [2:0] st;
    st = STEP_BAD;
    if (sel60) begin
      case (h)
        3'b100: st = 3'h0;
        3'b110: st = 3'h1;
        3'b111: st = 3'h2;
        3'b011: st = 3'h3;
        3'b001: st = 3'h4;
        3'b000: st = 3'h5;
        default: st = STEP_BAD;
      endcase
    end else begin
      case (h)
        3'b100: st = 3'h0;
        3'b110: st = 3'h1;
        3'b010: st = 3'h2;
        3'b011: st = 3'h3;
        3'b001: st = 3'h4;
        3'b101: st = 3'h5;
        default: st = STEP_BAD;
      endcase
    end
    return st;
  endfunction

  // one-hot phase masks, bit0 = A; reverse swaps upper and lower
  function automatic bcl_drv_s step_drive(input logic [2:0] st,
                                          input logic fwd);
    bcl_drv_s d;
    d = '0;
    case (st)
      3'h0: d = '{hi: 3'h1, lo: 3'h4};
      3'h1: d = '{hi: 3'h2, lo: 3'h4};
      3'h2: d = '{hi: 3'h2, lo: 3'h1};
      3'h3: d = '{hi: 3'h4, lo: 3'h1};
      3'h4: d = '{hi: 3'h4, lo: 3'h2};
      3'h5: d = '{hi: 3'h1, lo: 3'h2};
      default: d = '0;
    endcase
    if (!fwd) begin
      d = '{hi: d.lo, lo: d.hi};
    end
    return d;
  endfunction

  // ------------------------------------------------------------
  // combinational terms
  // ------------------------------------------------------------
  logic [2:0] step;
  logic invalid;
  logic supply_bad;
  logic wrap;
  logic conduct;
  logic bus_req;
  logic bus_hit;
  logic [NEV-1:0] ev_now;

  assign step = hall_step(ctl.hall, ctl.sel60);
  assign invalid = (step == STEP_BAD);
  assign supply_bad = ctl.uvlo | ctl.tsd;
  assign wrap = (s_reg.ramp >= s_reg.period - 16'h0001);
  // ramp at or above level or a trip this cycle blocks the stroke
  assign conduct = (s_reg.ramp < s_reg.level) & ~s_reg.cl_cyc
                   & ~ctl.cur_trip;
  assign bus_req = avs_read | avs_write;
  assign bus_hit = (s_reg.bus == BCL_ACK);
  assign ev_now = {supply_bad, s_reg.latched, ctl.cur_trip, invalid};

  always_comb begin
    s_next = s_reg;
    // sawtooth
    s_next.ramp = wrap ? 16'h0000 : s_reg.ramp + 16'h0001;
    // per-cycle trip flag: a trip on the wrap edge still counts
    if (wrap) begin
      s_next.cl_cyc = 1'b0;
    end
    if (ctl.cur_trip) begin
      s_next.cl_cyc = 1'b1;
    end
    // delayed latched shutdown
    if (s_reg.latch_mode && ctl.cur_trip) begin
      if (s_reg.dly_cnt >= s_reg.delay) begin
        s_next.latched = 1'b1;
      end else begin
        s_next.dly_cnt = s_reg.dly_cnt + 16'h0001;
      end
    end else begin
      s_next.dly_cnt = 16'h0000;
    end
    // drive selection, registered so outputs are glitch free
    if (supply_bad) begin
      s_next.drv = '0;
    end else if (ctl.brake) begin
      s_next.drv.hi = 3'h0;
      // lowers wait until the uppers are already off
      s_next.drv.lo = (s_reg.drv.hi == 3'h0) ? 3'h7 : 3'h0;
    end else if (!ctl.run_en || invalid || s_reg.latched
                 || !conduct) begin
      s_next.drv = '0;
    end else begin
      s_next.drv = step_drive(step, ctl.fwd);
    end
    s_next.fault = invalid | ~ctl.run_en | ctl.cur_trip
                   | s_reg.latched | supply_bad;
    // rising edges of fault sources set sticky status
    s_next.ev_prev = ev_now;
    // bus: one wait state, then the access completes
    s_next.bus = (bus_req && !bus_hit) ? BCL_ACK : BCL_IDLE;
    if (bus_hit && avs_write) begin
      if (avs_address == PERIOD_OFS) begin
        s_next.period = avs_writedata[15:0];
      end else if (avs_address == LEVEL_OFS) begin
        s_next.level = avs_writedata[15:0];
      end else if (avs_address == CONFIG_OFS) begin
        s_next.latch_mode = avs_writedata[CFG_LATCH_MODE];
        if (avs_writedata[CFG_LATCH_CLR]) begin
          s_next.latched = 1'b0;
          s_next.dly_cnt = 16'h0000;
        end
      end else if (avs_address == DELAY_OFS) begin
        s_next.delay = avs_writedata[15:0];
      end else if (avs_address == IRQ_STAT_OFS) begin
        s_next.irq_st = s_reg.irq_st & ~avs_writedata[NEV-1:0];
      end else if (avs_address == IRQ_MASK_OFS) begin
        s_next.irq_mask = avs_writedata[NEV-1:0];
      end
    end
    // set wins over a same-cycle clear
    s_next.irq_st = s_next.irq_st | (ev_now & ~s_reg.ev_prev);
    s_next.rdata = 32'h0000_0000;
    if (bus_req && !bus_hit && avs_read) begin
      if (avs_address == PERIOD_OFS) begin
        s_next.rdata = {16'h0000, s_reg.period};
      end else if (avs_address == LEVEL_OFS) begin
        s_next.rdata = {16'h0000, s_reg.level};
      end else if (avs_address == CONFIG_OFS) begin
        s_next.rdata = {31'h0, s_reg.latch_mode};
      end else if (avs_address == DELAY_OFS) begin
        s_next.rdata = {16'h0000, s_reg.delay};
      end else if (avs_address == STATUS_OFS) begin
        s_next.rdata = {17'h00000, s_reg.drv, ctl.hall,
                        s_reg.latched, s_reg.cl_cyc, s_reg.fault,
                        step};
      end else if (avs_address == IRQ_STAT_OFS) begin
        s_next.rdata = {28'h0, s_reg.irq_st};
      end else if (avs_address == IRQ_MASK_OFS) begin
        s_next.rdata = {28'h0, s_reg.irq_mask};
      end
    end
    if (sys_rst) begin
      s_next = '0;
      s_next.bus = BCL_IDLE;
      s_next.period = PERIOD_RST;
      s_next.level = LEVEL_RST;
      s_next.delay = DELAY_RST;
    end
  end

  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign drv = s_reg.drv;
  assign fault_out = 1'b0;
  // open drain: enable low pulls the line low while a fault stands
  assign fault_oe_n = ~s_reg.fault;
  assign avs_waitrequest = bus_req & ~bus_hit;
  assign avs_readdata = s_reg.rdata;
  assign irq = |(s_reg.irq_st & s_reg.irq_mask);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  enable_off_a: assert property (!ctl.run_en && !ctl.brake |=>
    drv == '0) else $error("drive on with run enable low");
  brake_top_a: assert property (ctl.brake |=> drv.hi == 3'h0)
    else $error("upper on while braking");
  brake_low_a: assert property (ctl.brake && !supply_bad
    |=> ##1 ($past(ctl.brake) && !$past(supply_bad)) -> drv.lo == 3'h7)
    else $error("lowers not braking");
  no_shoot_a: assert property (drv.lo != 3'h0 && $rose(drv.lo == 3'h7)
    |-> $past(drv.hi) == 3'h0)
    else $error("lowers braked while upper on");
  fault_pin_a: assert property ((invalid || !ctl.run_en || supply_bad)
    |=> !fault_oe_n) else $error("fault not shown");
  supply_off_a: assert property (supply_bad |=> drv == '0)
    else $error("drive on under supply fault");
  trip_cycle_a: assert property (ctl.cur_trip && !wrap && !ctl.brake
    ##1 !wrap && !ctl.brake |=> drv == '0)
    else $error("conduction after trip in cycle");
  ramp_off_a: assert property (s_reg.ramp >= s_reg.level && !ctl.brake
    |=> drv == '0) else $error("conduct above level");
  latch_hold_a: assert property (s_reg.latched && !bus_hit
    |=> s_reg.latched) else $error("latch released");
  one_pair_a: assert property (drv != '0 && !$past(ctl.brake) |->
    $onehot(drv.hi) && $onehot(drv.lo) && (drv.hi & drv.lo) == 3'h0)
    else $error("bad phase pair");
  bus_ack_a: assert property (bus_req && !bus_hit |=> !avs_waitrequest)
    else $error("bus answer late");


  // ------------------------------------------------------------
  // fault line and decode checks
  // ------------------------------------------------------------
  fault_clear_a: assert property (!invalid && ctl.run_en
    && !ctl.cur_trip && !s_reg.latched && !supply_bad
    |=> fault_oe_n) else $error("fault shown without cause");
  trip_fault_a: assert property (ctl.cur_trip |=> !fault_oe_n)
    else $error("trip not shown on fault line");
  latch_fault_a: assert property (s_reg.latched |=> !fault_oe_n)
    else $error("latched state not shown on fault line");
  bad60_code_a: assert property (ctl.sel60
    && ctl.hall inside {3'b010, 3'b101} |-> invalid)
    else $error("60 degree bad code accepted");
  bad120_code_a: assert property (!ctl.sel60
    && ctl.hall inside {3'b000, 3'b111} |-> invalid)
    else $error("120 degree bad code accepted");
  good_code_a: assert property ((ctl.sel60
    ? !(ctl.hall inside {3'b010, 3'b101})
    : !(ctl.hall inside {3'b000, 3'b111})) |-> !invalid)
    else $error("valid code refused");

  // ------------------------------------------------------------
  // direction, latch and ramp checks
  // ------------------------------------------------------------
  // code 100 is step zero in both phasings, so it pins the table
  fwd_step_a: assert property (ctl.hall == 3'b100 && ctl.fwd
    && ctl.run_en && !ctl.brake && !supply_bad && conduct
    && !s_reg.latched |=> drv.hi == 3'h1 && drv.lo == 3'h4)
    else $error("forward step pair wrong");
  rev_step_a: assert property (ctl.hall == 3'b100 && !ctl.fwd
    && ctl.run_en && !ctl.brake && !supply_bad && conduct
    && !s_reg.latched |=> drv.hi == 3'h4 && drv.lo == 3'h1)
    else $error("reverse step pair not swapped");
  latch_set_a: assert property (s_reg.latch_mode && ctl.cur_trip
    && s_reg.dly_cnt >= s_reg.delay && !bus_hit |=> s_reg.latched)
    else $error("latch not set after delay");
  latch_off_a: assert property (s_reg.latched && !ctl.brake
    |=> drv == '0) else $error("drive on while latched");
  ramp_wrap_a: assert property (wrap |=> s_reg.ramp == 16'h0000)
    else $error("ramp did not wrap");
  ramp_step_a: assert property (!wrap
    |=> s_reg.ramp == $past(s_reg.ramp) + 16'h0001)
    else $error("ramp did not advance");

  // ------------------------------------------------------------
  // interrupt and bus checks
  // ------------------------------------------------------------
  trip_irq_a: assert property ($rose(ctl.cur_trip)
    |=> s_reg.irq_st[EV_TRIP]) else $error("trip event lost");
  bad_irq_a: assert property ($rose(invalid)
    |=> s_reg.irq_st[EV_INVALID]) else $error("code event lost");
  supply_irq_a: assert property ($rose(supply_bad)
    |=> s_reg.irq_st[EV_SUPPLY]) else $error("supply event lost");
  rdata_idle_a: assert property (!bus_req |=> avs_readdata == 32'h0)
    else $error("read data left standing");
  wait_first_a: assert property (bus_req && !bus_hit
    |-> avs_waitrequest) else $error("bus answered without wait");

  rev_c: cover property (!ctl.fwd && drv.hi != 3'h0);
  run_c: cover property (drv.hi != 3'h0 ##[1:20] drv.hi != $past(drv.hi));
  brake_c: cover property (drv.lo == 3'h7);
  latch_c: cover property ($rose(s_reg.latched));
  irq_c: cover property ($rose(irq));

endmodule : bcl_core

// ===== sim/bcl_hall_model.sv
// hall sensor model: turns a rotor step into a sensor code
module bcl_hall_model (
  // rotor step, 6 and 7 pick a broken sensor pattern
  input wire logic [2:0] step,
  input wire logic sel60,
  // sensor lines {a, b, c}
  output logic [2:0] hall
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    case (step)
      3'h0: hall = 3'h4;
      3'h1: hall = 3'h6;
      3'h2: hall = sel60 ? 3'h7 : 3'h2;
      3'h3: hall = 3'h3;
      3'h4: hall = 3'h1;
      3'h5: hall = sel60 ? 3'h0 : 3'h5;
      default: hall = sel60 ? 3'h2 : 3'h7;
    endcase
  end
endmodule // bcl_hall_model

// ===== sim/bcl_commutation_logic_tb.sv
// testbench: bus, commutation, protection and pwm checks
module bcl_commutation_logic_tb;
  import bcl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic mclk = 0, sys_rst = 1, rd = 0, wr = 0, smp = 0, lat = 0;
  logic run_en = 1, brake = 0, sel60 = 1, fwd = 1, uvlo = 0, tsd = 0;
  logic trip = 0;
  logic [2:0] st = 0, hall;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat, r, e;
  logic wreq, f_out, f_oe_n, irq;
  bcl_ctl_s ctl;
  bcl_drv_s drv;
  logic [31:0] expq[$];
  logic [1:0] hp[8] = '{0, 1, 1, 2, 2, 0, 0, 0};
  logic [1:0] lp[8] = '{2, 2, 0, 0, 1, 1, 0, 0};
  integer seed = 32'h6883, n_mismatch = 0, n_tests = 0, k;
  wire [31:0] obs = {25'h0, f_oe_n, drv};
  assign ctl = {run_en, brake, sel60, fwd, uvlo, tsd, trip, hall};
  always #25 mclk = ~mclk;
  bcl_core DUT (.mclk(mclk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .ctl(ctl), .drv(drv),
    .fault_out(f_out), .fault_oe_n(f_oe_n), .irq(irq));
  bcl_hall_model u_hall (.step(st), .sel60(sel60), .hall(hall));
  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [31:0] exp_drv();
    logic [2:0] h, l;
    logic bad;
    bad = st > 3'h5;
    h = 3'h1 << hp[st];
    l = 3'h1 << lp[st];
    if (!fwd) {h, l} = {l, h};
    if (uvlo || tsd || (!brake && (!run_en || bad || trip || lat)))
      {h, l} = 6'h0;
    else if (brake) {h, l} = 6'h07;
    return {25'h0, !(bad || !run_en || trip || lat || uvlo || tsd), h, l};
  endfunction
  // the monitor samples mid-cycle, clear of the edge updates
  always @(negedge mclk) begin
    if (rd && !wreq) begin
      e = expq.pop_front();
      chk(rdat, e);
    end else if (smp) begin
      e = expq.pop_front();
      chk(obs, e);
    end
  end
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  // d is write data, or the expected value of a read
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    if (!w) expq.push_back(d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (wreq && n < 20);
    if (wreq) begin
      n_mismatch++;
      results();
    end
    @(posedge mclk);
    wr <= 0;
    rd <= 0;
    @(posedge mclk);
  endtask
  // brake needs two edges, so three are allowed before looking
  task automatic look;
    repeat (3) @(posedge mclk);
    expq.push_back(exp_drv());
    smp <= 1;
    @(posedge mclk);
    smp <= 0;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    bus(0, PERIOD_OFS, {16'h0, PERIOD_RST});
    bus(0, DELAY_OFS, {16'h0, DELAY_RST});
    bus(0, IRQ_MASK_OFS, 32'h0);
    bus(1, PERIOD_OFS, 32'h10);
    bus(1, LEVEL_OFS, 32'hffff);
    bus(0, PERIOD_OFS, 32'h10);
    bus(1, 8'h1c, 32'h5);
    bus(0, 8'h1c, 32'h0);
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      st <= r[2:0];
      sel60 <= r[3];
      fwd <= r[4];
      brake <= r[6:5] == 2'h0;
      run_en <= r[9:7] != 3'h0;
      uvlo <= r[12:10] == 3'h0;
      tsd <= r[15:13] == 3'h0;
      look();
    end
    st <= 0;
    fwd <= 1;
    brake <= 0;
    run_en <= 1;
    uvlo <= 0;
    tsd <= 0;
    bus(1, IRQ_STAT_OFS, 32'hf);
    bus(1, IRQ_MASK_OFS, 32'h2);
    chk(irq, 0);
    trip <= 1;
    look();
    chk(irq, 1);
    trip <= 0;
    repeat (20) @(posedge mclk);
    look();
    bus(1, IRQ_STAT_OFS, 32'h2);
    chk(irq, 0);
    // latch mode: trip held well past the delay
    bus(1, CONFIG_OFS, 32'h1);
    bus(1, DELAY_OFS, 32'h4);
    trip <= 1;
    repeat (10) @(posedge mclk);
    trip <= 0;
    lat = 1;
    repeat (20) @(posedge mclk);
    look();
    bus(1, CONFIG_OFS, 32'h2);
    lat = 0;
    look();
    brake <= 1;
    repeat (2) @(negedge mclk);
    chk(drv, 6'h0);
    @(negedge mclk);
    chk(drv, 6'h07);
    @(posedge mclk);
    brake <= 0;
    bus(1, LEVEL_OFS, 32'h8);
    k = 0;
    repeat (32) begin
      @(negedge mclk);
      k = k + (drv != 6'h0);
    end
    chk(k, 16);
    results();
  end
endmodule // bcl_commutation_logic_tb
